// File: hdl/daio_pkg.sv
// Shared constants, types and the register map of the digital audio port.
package daio_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int WCK_TIMEOUT_NS = 40000;
  localparam int WCK_TIMEOUT_CYC = WCK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int NCO_W = 24;

  // ---------------------------------------------------------------------
  // Sample rates, word clock period classes in system clocks
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    RATE_NONE = 3'h0, RATE_32K = 3'h1, RATE_44K1 = 3'h2, RATE_48K = 3'h3,
    RATE_88K2 = 3'h4, RATE_96K = 3'h5, RATE_176K4 = 3'h6, RATE_192K = 3'h7
  } daio_rate_e;
  typedef enum logic [1:0] {
    SPD_SINGLE = 2'h0, SPD_DOUBLE = 2'h1, SPD_QUAD = 2'h2
  } daio_speed_e;
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0, SRC_WORD = 2'h1, SRC_DIGITAL = 2'h2
  } daio_src_e;

  localparam logic [9:0] PER_MAX = 10'h384;   // 900 clocks
  localparam logic [9:0] PER_32K = 10'h2A2;   // 674
  localparam logic [9:0] PER_44K1 = 10'h220;  // 544
  localparam logic [9:0] PER_48K = 10'h192;   // 402
  localparam logic [9:0] PER_88K2 = 10'h110;  // 272
  localparam logic [9:0] PER_96K = 10'h0C9;   // 201
  localparam logic [9:0] PER_176K4 = 10'h088; // 136
  localparam logic [9:0] PER_MIN = 10'h06E;   // 110
  localparam logic [9:0] PER_TOL = 10'h004;

  function automatic logic [NCO_W-1:0] nco_inc(input daio_rate_e r);
    longint hz;
    case (r)
      RATE_32K: hz = 32000;
      RATE_44K1: hz = 44100;
      RATE_48K: hz = 48000;
      RATE_88K2: hz = 88200;
      RATE_96K: hz = 96000;
      RATE_176K4: hz = 176400;
      RATE_192K: hz = 192000;
      default: hz = 0;
    endcase
    return NCO_W'((hz * (longint'(1) << NCO_W)) / longint'(CLK_HZ));
  endfunction

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CSTAT = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0080;

  typedef struct packed {
    logic [2:0] master_rate;   // [8:6]
    logic [1:0] clk_src;       // [5:4]
    logic single_speed_out;    // [3]
    logic opt_spdif;           // [2]
    logic coax_pro;            // [1]
    logic wck_out_mode;        // [0]
  } daio_ctrl_s;

  // Channel status layout: consumer/pro flag in bit 0, rate field placed
  // in byte 0 bits 7:6 (pro) or byte 3 bits 3:0 (consumer).
  localparam int CS_PRO_BIT = 0;
  localparam int CS_PRO_FS_LSB = 6;
  localparam int CS_CON_FS_LSB = 24;
  localparam logic [1:0] OPT_SPDIF_CH_LAST = 2'h1;
  localparam logic [4:0] MIX_OPT_BASE = 5'h0D;   // Mixer channel 13.

  typedef struct packed {
    logic valid;
    logic [2:0] slot;
    logic [1:0] sub;
    logic [23:0] data;
  } daio_slot_s;

endpackage

// File: hdl/daio_sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module daio_sync3 (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_async,
  output logic o_level
);
  logic [2:0] ff_r;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ff_r <= 3'h0;
    end else begin
      ff_r <= {ff_r[1:0], i_async};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_level <= 1'b0;
    end else if (ff_r[1] == ff_r[2]) begin
      o_level <= ff_r[2];
    end
  end
endmodule // daio_sync3

// File: hdl/daio_wck_meter.sv
// Word clock period meter: presence, rate class and lock of the input.
`timescale 1ns/1ns
module daio_wck_meter (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_en,
  input wire logic i_level,
  output logic o_present,
  output logic o_lock,
  output daio_pkg::daio_rate_e o_rate
);
  logic lvl_d_r;
  logic [9:0] cnt_r;
  logic [9:0] last_r;
  logic rise;
  logic [9:0] diff;
  daio_pkg::daio_rate_e cls;

  assign rise = i_level & ~lvl_d_r;
  assign diff = (cnt_r > last_r) ? cnt_r - last_r : last_r - cnt_r;

  always_comb begin
    if (cnt_r > daio_pkg::PER_MAX || cnt_r < daio_pkg::PER_MIN) begin
      cls = daio_pkg::RATE_NONE;
    end else if (cnt_r > daio_pkg::PER_32K) begin
      cls = daio_pkg::RATE_32K;
    end else if (cnt_r > daio_pkg::PER_44K1) begin
      cls = daio_pkg::RATE_44K1;
    end else if (cnt_r > daio_pkg::PER_48K) begin
      cls = daio_pkg::RATE_48K;
    end else if (cnt_r > daio_pkg::PER_88K2) begin
      cls = daio_pkg::RATE_88K2;
    end else if (cnt_r > daio_pkg::PER_96K) begin
      cls = daio_pkg::RATE_96K;
    end else if (cnt_r > daio_pkg::PER_176K4) begin
      cls = daio_pkg::RATE_176K4;
    end else begin
      cls = daio_pkg::RATE_192K;
    end
  end

  // Lock needs two matching periods; a late edge or bad period drops it.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lvl_d_r <= 1'b0;
      cnt_r <= 10'h0;
      last_r <= 10'h0;
      o_present <= 1'b0;
      o_lock <= 1'b0;
      o_rate <= daio_pkg::RATE_NONE;
    end else if (!i_en || cnt_r == 10'(daio_pkg::WCK_TIMEOUT_CYC)) begin
      lvl_d_r <= i_level;
      cnt_r <= 10'h0;
      o_present <= 1'b0;
      o_lock <= 1'b0;
      o_rate <= daio_pkg::RATE_NONE;
    end else if (rise) begin
      lvl_d_r <= i_level;
      cnt_r <= 10'h1;
      last_r <= cnt_r;
      o_present <= 1'b1;
      o_lock <= (cls != daio_pkg::RATE_NONE) && (diff <= daio_pkg::PER_TOL);
      o_rate <= cls;
    end else begin
      lvl_d_r <= i_level;
      cnt_r <= cnt_r + 10'h1;
    end
  end
endmodule // daio_wck_meter

// File: hdl/daio_port.sv
// Digital audio port: channel mapping, channel status and word clock.
//
// Notes on behaviour
// - Optical receive gives 8 channels single, 4 double, 2 quad speed.
// - Optical transmit sends 8 channels single, 4 double, 2 quad speed.
// - Optical transmitter may instead run as two-channel SPDIF output.
// - Incoming AES channel status is ignored and changes nothing.
// - Coaxial receiver takes SPDIF and AES, consumer or professional.
// - Optical SPDIF is detected and routed to mixer channels 13 and 14.
// - Every SPDIF/AES output carries a freshly built channel status.
// - Coax status consumer or pro by setting; pro doubles carrier level.
// - Optical SPDIF output takes mixer optical channels one and two.
// - Optical SPDIF output always marks consumer channel status.
// - Word clock connector is input or output, chosen by setting.
// - Word clock input used only in input mode with a valid signal.
// - Word clock input adapts to single, double or quad speed itself.
// - Valid word clock lights presence indicator and reports lock; the lock bit shows it only with word clock selected as source.
// - Output mode emits current rate, master or selected source rate.
// - Lost external clock falls back to master at nearest standard rate.
// - Single-speed output option keeps word clock within 32 to 48 kHz.
// - Internal sample clock regenerated free of word clock jitter.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
module daio_port (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_wck_in,
  output logic o_wck_out,
  output logic o_wck_oe,
  input wire logic i_dig_lock,
  input wire daio_pkg::daio_rate_e i_dig_rate,
  input wire logic i_opt_is_spdif,
  input wire daio_pkg::daio_slot_s i_opt_rx,
  input wire daio_pkg::daio_slot_s i_coax_rx,
  input wire daio_pkg::daio_slot_s i_mix_tx,
  output daio_pkg::daio_slot_s o_opt_mix,
  output logic [4:0] o_opt_mix_ch,
  output daio_pkg::daio_slot_s o_coax_mix,
  output daio_pkg::daio_slot_s o_opt_tx,
  output logic o_opt_tx_spdif,
  output logic [31:0] o_coax_cs,
  output logic [31:0] o_opt_cs,
  output logic o_coax_level_hi,
  output logic o_word_clock_present_indicator,
  output logic o_sample_tick
);

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  daio_pkg::daio_ctrl_s ctrl_r;
  logic lock_r;
  logic fb_pend_r;
  logic fallback_r;
  daio_pkg::daio_rate_e fb_rate_r;
  daio_pkg::daio_rate_e cur_rate_r;
  daio_pkg::daio_speed_e speed;
  logic wck_present;
  logic wck_lock;
  daio_pkg::daio_rate_e wck_rate;
  logic opt_spdif_rx;
  logic [31:0] status;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= daio_pkg::daio_ctrl_s'(daio_pkg::CTRL_RESET[8:0]);
    end else if (i_wr && i_addr == daio_pkg::ADDR_CTRL) begin
      ctrl_r <= daio_pkg::daio_ctrl_s'(i_wdata[8:0]);
    end
  end

  assign status = {20'h0, opt_spdif_rx, speed, cur_rate_r, wck_rate,
                   fallback_r, lock_r, wck_present};

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 32'h0;
    end else if (!i_rd) begin
      o_rdata <= 32'h0;
    end else if (i_addr == daio_pkg::ADDR_CTRL) begin
      o_rdata <= {23'h0, ctrl_r};
    end else if (i_addr == daio_pkg::ADDR_STATUS) begin
      o_rdata <= status;
    end else if (i_addr == daio_pkg::ADDR_CSTAT) begin
      o_rdata <= o_coax_cs;
    end else begin
      o_rdata <= 32'h0;
    end
  end

  // ---------------------------------------------------------------------
  // Word clock input
  // ---------------------------------------------------------------------
  logic wck_level;
  logic opt_spdif_sync;

  daio_sync3 u_wck_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_async(i_wck_in),
    .o_level(wck_level)
  );

  daio_sync3 u_spdif_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_async(i_opt_is_spdif),
    .o_level(opt_spdif_sync)
  );
  assign opt_spdif_rx = opt_spdif_sync;

  // The meter is held in reset while the connector drives out.
  daio_wck_meter u_meter (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_en(~ctrl_r.wck_out_mode),
    .i_level(wck_level),
    .o_present(wck_present),
    .o_lock(wck_lock),
    .o_rate(wck_rate)
  );
  assign o_word_clock_present_indicator = wck_present;

  // ---------------------------------------------------------------------
  // Clock source selection and fallback
  // ---------------------------------------------------------------------
  logic ext_ok;
  daio_pkg::daio_rate_e ext_rate;
  daio_pkg::daio_rate_e rate_nxt;

  always_comb begin
    ext_ok = 1'b0;
    ext_rate = daio_pkg::RATE_NONE;
    if (ctrl_r.clk_src == daio_pkg::SRC_WORD) begin
      ext_ok = wck_lock && !ctrl_r.wck_out_mode;
      ext_rate = wck_rate;
    end else if (ctrl_r.clk_src == daio_pkg::SRC_DIGITAL) begin
      ext_ok = i_dig_lock && i_dig_rate != daio_pkg::RATE_NONE;
      ext_rate = i_dig_rate;
    end
  end

  // Lock drops first; the fallback flag follows one edge later.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lock_r <= 1'b0;
      fb_pend_r <= 1'b0;
      fallback_r <= 1'b0;
      fb_rate_r <= daio_pkg::RATE_44K1;
    end else begin
      lock_r <= ext_ok;
      fb_pend_r <= lock_r && !ext_ok;
      if (ext_ok) begin
        fallback_r <= 1'b0;
        fb_rate_r <= ext_rate;
      end else if (fb_pend_r) begin
        fallback_r <= 1'b1;
      end
    end
  end

  always_comb begin
    if (ctrl_r.clk_src == daio_pkg::SRC_INTERNAL) begin
      rate_nxt = daio_pkg::daio_rate_e'(ctrl_r.master_rate);
    end else if (lock_r) begin
      rate_nxt = ext_rate;
    end else if (fallback_r) begin
      rate_nxt = fb_rate_r;
    end else begin
      rate_nxt = daio_pkg::daio_rate_e'(ctrl_r.master_rate);
    end
    if (rate_nxt == daio_pkg::RATE_NONE) begin
      rate_nxt = daio_pkg::RATE_44K1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_rate_r <= daio_pkg::RATE_44K1;
    end else begin
      cur_rate_r <= rate_nxt;
    end
  end

  always_comb begin
    case (cur_rate_r)
      daio_pkg::RATE_88K2, daio_pkg::RATE_96K: speed = daio_pkg::SPD_DOUBLE;
      daio_pkg::RATE_176K4, daio_pkg::RATE_192K: speed = daio_pkg::SPD_QUAD;
      default: speed = daio_pkg::SPD_SINGLE;
    endcase
  end

  // ---------------------------------------------------------------------
  // Sample clock and word clock output
  // ---------------------------------------------------------------------
  // Both oscillators step by a constant per rate class, so edge jitter on
  // the incoming reference never reaches the regenerated clocks.
  logic [daio_pkg::NCO_W-1:0] smp_acc_r;
  logic [daio_pkg::NCO_W-1:0] wck_acc_r;
  logic smp_msb_d_r;
  daio_pkg::daio_rate_e out_rate;

  always_comb begin
    out_rate = cur_rate_r;
    if (ctrl_r.single_speed_out) begin
      case (cur_rate_r)
        daio_pkg::RATE_88K2: out_rate = daio_pkg::RATE_44K1;
        daio_pkg::RATE_176K4: out_rate = daio_pkg::RATE_44K1;
        daio_pkg::RATE_96K: out_rate = daio_pkg::RATE_48K;
        daio_pkg::RATE_192K: out_rate = daio_pkg::RATE_48K;
        default: out_rate = cur_rate_r;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      smp_acc_r <= '0;
      smp_msb_d_r <= 1'b0;
    end else begin
      smp_acc_r <= smp_acc_r + daio_pkg::nco_inc(cur_rate_r);
      smp_msb_d_r <= smp_acc_r[daio_pkg::NCO_W-1];
    end
  end
  assign o_sample_tick = smp_acc_r[daio_pkg::NCO_W-1] & ~smp_msb_d_r;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wck_acc_r <= '0;
      o_wck_out <= 1'b0;
    end else begin
      wck_acc_r <= wck_acc_r + daio_pkg::nco_inc(out_rate);
      o_wck_out <= ctrl_r.wck_out_mode & wck_acc_r[daio_pkg::NCO_W-1];
    end
  end
  assign o_wck_oe = ctrl_r.wck_out_mode;

  // ---------------------------------------------------------------------
  // Optical receive mapping
  // ---------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_opt_mix <= '0;
      o_opt_mix_ch <= 5'h0;
    end else begin
      o_opt_mix <= '0;
      o_opt_mix.data <= i_opt_rx.data;
      o_opt_mix_ch <= daio_pkg::MIX_OPT_BASE + 5'(i_opt_rx.slot);
      if (opt_spdif_rx) begin
        o_opt_mix.valid <= i_opt_rx.valid
                           && i_opt_rx.slot[2:1] == 2'h0;
        o_opt_mix.slot <= i_opt_rx.slot;
      end else begin
        case (speed)
          daio_pkg::SPD_DOUBLE: begin
            o_opt_mix.valid <= i_opt_rx.valid;
            o_opt_mix.slot <= {1'b0, i_opt_rx.slot[2:1]};
            o_opt_mix.sub <= {1'b0, i_opt_rx.slot[0]};
          end
          daio_pkg::SPD_QUAD: begin
            o_opt_mix.valid <= i_opt_rx.valid;
            o_opt_mix.slot <= {2'h0, i_opt_rx.slot[2]};
            o_opt_mix.sub <= i_opt_rx.slot[1:0];
          end
          default: begin
            o_opt_mix.valid <= i_opt_rx.valid;
            o_opt_mix.slot <= i_opt_rx.slot;
          end
        endcase
      end
    end
  end

  // Coax/AES audio passes untouched; its channel status never reaches
  // this block, so nothing it says can steer it.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_coax_mix <= '0;
    end else begin
      o_coax_mix <= i_coax_rx;
    end
  end

  // ---------------------------------------------------------------------
  // Optical transmit mapping
  // ---------------------------------------------------------------------
  localparam logic [1:0] OPT_LAST = daio_pkg::OPT_SPDIF_CH_LAST;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_opt_tx <= '0;
      o_opt_tx_spdif <= 1'b0;
    end else begin
      o_opt_tx <= '0;
      o_opt_tx.data <= i_mix_tx.data;
      o_opt_tx_spdif <= ctrl_r.opt_spdif;
      if (ctrl_r.opt_spdif) begin
        o_opt_tx.valid <= i_mix_tx.valid
                          && i_mix_tx.slot <= 3'(OPT_LAST);
        o_opt_tx.slot <= i_mix_tx.slot;
      end else begin
        case (speed)
          daio_pkg::SPD_DOUBLE: begin
            o_opt_tx.valid <= i_mix_tx.valid && !i_mix_tx.slot[2];
            o_opt_tx.slot <= {i_mix_tx.slot[1:0], i_mix_tx.sub[0]};
          end
          daio_pkg::SPD_QUAD: begin
            o_opt_tx.valid <= i_mix_tx.valid
                              && i_mix_tx.slot[2:1] == 2'h0;
            o_opt_tx.slot <= {i_mix_tx.slot[0], i_mix_tx.sub};
          end
          default: begin
            o_opt_tx.valid <= i_mix_tx.valid;
            o_opt_tx.slot <= i_mix_tx.slot;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------
  // Channel status generation
  // ---------------------------------------------------------------------
  function automatic logic [31:0] make_cs(input logic pro,
                                          input daio_pkg::daio_rate_e r);
    logic [31:0] cs;
    cs = 32'h0;
    cs[daio_pkg::CS_PRO_BIT] = pro;
    if (pro) begin
      cs[daio_pkg::CS_PRO_FS_LSB +: 2] = r[1:0];
    end else begin
      cs[daio_pkg::CS_CON_FS_LSB +: 4] = {1'b0, r};
    end
    return cs;
  endfunction

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_coax_cs <= 32'h0;
      o_opt_cs <= 32'h0;
      o_coax_level_hi <= 1'b0;
    end else begin
      o_coax_cs <= make_cs(ctrl_r.coax_pro, cur_rate_r);
      o_opt_cs <= make_cs(1'b0, cur_rate_r);
      o_coax_level_hi <= ctrl_r.coax_pro;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  oe_follows_mode_a: assert property (
    o_wck_oe == ctrl_r.wck_out_mode)
    else $error("word clock enable differs from mode");
  out_quiet_in_in_a: assert property (
    !ctrl_r.wck_out_mode |=> !o_wck_out)
    else $error("word clock driven in input mode");
  no_lock_out_mode_a: assert property (
    ctrl_r.wck_out_mode && ctrl_r.clk_src == daio_pkg::SRC_WORD |=> !lock_r)
    else $error("word clock used in output mode");
  lock_before_fb_a: assert property (
    $fell(lock_r) && !ext_ok |-> !fallback_r ##2 fallback_r)
    else $error("fallback not two edges after lock loss");
  fb_rate_a: assert property (
    fallback_r && !lock_r && ctrl_r.clk_src != daio_pkg::SRC_INTERNAL
    |=> cur_rate_r == $past(fb_rate_r))
    else $error("fallback rate not applied");
  single_out_a: assert property (
    ctrl_r.single_speed_out |-> out_rate inside {daio_pkg::RATE_32K,
    daio_pkg::RATE_44K1, daio_pkg::RATE_48K})
    else $error("single speed output out of range");
  opt_cs_cons_a: assert property (
    ##1 !o_opt_cs[daio_pkg::CS_PRO_BIT])
    else $error("optical status not consumer");
  coax_level_a: assert property (
    ctrl_r.coax_pro |=> o_coax_level_hi && o_coax_cs[daio_pkg::CS_PRO_BIT])
    else $error("pro status without high carrier");
  spdif_tx_ch_a: assert property (
    ctrl_r.opt_spdif && i_mix_tx.valid && i_mix_tx.slot > 3'h1
    |=> !o_opt_tx.valid)
    else $error("optical spdif sent channel beyond two");
  quad_rx_a: assert property (
    !opt_spdif_rx && speed == daio_pkg::SPD_QUAD |=> o_opt_mix.slot < 3'h2)
    else $error("quad speed delivered channel beyond two");

  fallback_c: cover property (lock_r ##1 !lock_r ##2 fallback_r);
  wck_lock_c: cover property (wck_lock && ctrl_r.clk_src == daio_pkg::SRC_WORD);
  spdif_rx_c: cover property (opt_spdif_rx && o_opt_mix.valid);
  quad_out_c: cover property (ctrl_r.single_speed_out
                              && speed == daio_pkg::SPD_QUAD);

endmodule // daio_port

// File: tb/daio_wck_src.sv
// Far-side word clock source model for the digital audio port.
`timescale 1ns/1ns
module daio_wck_src (
  input wire logic i_en,
  input wire logic [31:0] i_half_ns,
  output logic o_wck
);
  // Clock master on the line while the port is in input mode; it stands still at 0 when stopped.
  initial begin
    o_wck = 1'b0;
    forever begin
      #(i_half_ns);
      o_wck = i_en ? ~o_wck : 1'b0;
    end
  end
endmodule // daio_wck_src

// File: tb/digital_audio_io_clocking_tb.sv
// Self-checking bench for the digital audio port.
`timescale 1ns/1ns
module digital_audio_io_clocking_tb;
  logic i_sys_clk, i_rstn, i_wr, i_rd, i_dig_lock, i_opt_is_spdif, wck_en;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, o_coax_cs, o_opt_cs, rd_v;
  logic o_wck_out, o_wck_oe, o_opt_tx_spdif, o_coax_level_hi, o_sample_tick;
  logic o_word_clock_present_indicator, wck_line, src_wck;
  logic [4:0] o_opt_mix_ch;
  daio_pkg::daio_rate_e i_dig_rate;
  daio_pkg::daio_slot_s i_opt_rx, i_coax_rx, i_mix_tx, s;
  daio_pkg::daio_slot_s o_opt_mix, o_coax_mix, o_opt_tx;
  int failures, samples_checked, n, m, half_ns;

  assign wck_line = o_wck_oe ? o_wck_out : src_wck;
  daio_wck_src src_u (.i_en(wck_en), .i_half_ns(half_ns), .o_wck(src_wck));
  daio_port dut_u (.*, .i_wck_in(wck_line));

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    rd_v = o_rdata;
  endtask

  task automatic send(input daio_pkg::daio_slot_s v);
    @(posedge i_sys_clk);
    i_opt_rx <= v;
    i_coax_rx <= v;
    i_mix_tx <= v;
    @(posedge i_sys_clk);
    i_opt_rx <= '0;
    i_coax_rx <= '0;
    i_mix_tx <= '0;
    #1;
  endtask

  // Counts rising edges of the emitted word clock over 200 us.
  task automatic cnt();
    logic p;
    n = 0;
    m = 0;
    p = o_wck_out;
    repeat (5000) begin
      @(posedge i_sys_clk);
      #1;
      if (o_wck_out && !p) n++;
      if (o_sample_tick) m++;
      p = o_wck_out;
    end
  endtask

  task automatic wck_lock(input logic [9:0] per, input logic [2:0] r);
    half_ns = int'(per) * daio_pkg::CLK_PERIOD_NS / 2;
    wck_en = 1'b1;
    repeat (6 * 900) @(posedge i_sys_clk);
    chk(o_word_clock_present_indicator, 1'b1);
    rd(daio_pkg::ADDR_STATUS);
    chk(rd_v[5:0], {r, 3'h3});
    chk(rd_v[8:6], r);
    chk(rd_v[10:9], (r > 3'h5) ? 2'h2 : (r > 3'h3) ? 2'h1 : 2'h0);
  endtask

  initial begin
    repeat (60000) @(posedge i_sys_clk);
    failures++;
    end_sim();
  end

  initial begin
    {i_rstn, i_wr, i_rd, i_dig_lock, i_opt_is_spdif, wck_en} = '0;
    {i_addr, i_wdata, i_opt_rx, i_coax_rx, i_mix_tx} = '0;
    i_dig_rate = daio_pkg::RATE_NONE;
    half_ns = 10000;
    repeat (3) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    rd(daio_pkg::ADDR_CTRL);
    chk(rd_v, daio_pkg::CTRL_RESET);
    rd(4'hC);
    chk(rd_v, 32'h0);
    chk(o_wck_oe, 1'b0);
    for (int i = 0; i < 8; i++) begin
      s = {1'b1, 3'(i), 2'h0, 24'hA5A500 | 24'(i)};
      send(s);
      chk({o_opt_mix.valid, o_opt_mix.slot, o_opt_mix.data},
          {s.valid, s.slot, s.data});
      chk(o_opt_mix_ch, daio_pkg::MIX_OPT_BASE + 5'(i));
      chk({o_opt_tx.valid, o_opt_tx.slot, o_opt_tx.data},
          {s.valid, s.slot, s.data});
      chk(o_coax_mix, s);
    end
    $display("test channel map done");
    i_opt_is_spdif <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    s = {1'b1, 3'h1, 2'h0, 24'h123456};
    send(s);
    chk(o_opt_mix_ch, daio_pkg::MIX_OPT_BASE + 5'h1);
    chk({o_opt_mix.valid, o_opt_mix.data}, {s.valid, s.data});
    wr(daio_pkg::ADDR_CTRL, 32'h0000_0086);
    send(s);
    chk(o_opt_tx_spdif, 1'b1);
    chk({o_opt_tx.valid, o_opt_tx.slot}, {1'b1, 3'h1});
    chk(o_opt_cs[daio_pkg::CS_PRO_BIT], 1'b0);
    chk(o_coax_cs[daio_pkg::CS_PRO_BIT], 1'b1);
    chk(o_coax_level_hi, 1'b1);
    $display("test channel status done");
    wr(daio_pkg::ADDR_CTRL, 32'h0000_0081);
    chk(o_wck_oe, 1'b1);
    cnt();
    chk(n >= 8 && n <= 9, 1'b1);
    chk(m >= 8 && m <= 9, 1'b1);
    wr(daio_pkg::ADDR_CTRL, 32'h0000_0149);
    cnt();
    chk(n >= 9 && n <= 10, 1'b1);
    chk(m >= 19 && m <= 20, 1'b1);
    $display("test word clock out done");
    wr(daio_pkg::ADDR_CTRL, 32'h0000_0090);
    i_opt_is_spdif <= 1'b0;
    wck_lock(daio_pkg::PER_44K1 + 10'h10, 3'(daio_pkg::RATE_44K1));
    wck_lock(daio_pkg::PER_88K2 + 10'h8, 3'(daio_pkg::RATE_88K2));
    s = {1'b1, 3'h5, 2'h1, 24'h00C0DE};
    send(s);
    chk({o_opt_mix.valid, o_opt_mix.slot, o_opt_mix.sub},
        {1'b1, 3'h2, 2'h1});
    chk(o_opt_tx.valid, 1'b0);
    s = {1'b1, 3'h1, 2'h1, 24'h00C0DE};
    send(s);
    chk({o_opt_tx.valid, o_opt_tx.slot}, {1'b1, 3'h3});
    wck_lock(daio_pkg::PER_176K4 + 10'h2, 3'(daio_pkg::RATE_176K4));
    s = {1'b1, 3'h5, 2'h2, 24'h00C0DE};
    send(s);
    chk({o_opt_mix.valid, o_opt_mix.slot, o_opt_mix.sub},
        {1'b1, 3'h1, 2'h1});
    chk(o_opt_tx.valid, 1'b0);
    s = {1'b1, 3'h1, 2'h2, 24'h00C0DE};
    send(s);
    chk({o_opt_tx.valid, o_opt_tx.slot}, {1'b1, 3'h6});
    wck_en = 1'b0;
    n = 0;
    while (o_word_clock_present_indicator && n < 3000) begin
      @(posedge i_sys_clk);
      n++;
    end
    chk(n < 3000, 1'b1);
    repeat (8) @(posedge i_sys_clk);
    rd(daio_pkg::ADDR_STATUS);
    chk(rd_v[2:1], 2'h2);
    chk(rd_v[8:6], 3'(daio_pkg::RATE_176K4));
    $display("test word clock in done");
    end_sim();
  end
endmodule // digital_audio_io_clocking_tb
